//--- logic/ustc_clk_div.sv
// Tick divider: one output pulse for every ratio input ticks
`timescale 1ns/1ps
`default_nettype none

module ustc_clk_div #(
	parameter int W = 9
) (
	input  wire logic         core_clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         tick_in,
	input  wire logic [W-1:0] ratio_in,
	output logic              tick_out
);

	typedef struct packed {
		logic [W-1:0] count;
		logic         tick;
	} ustc_div_state_t;

	ustc_div_state_t st_reg;
	ustc_div_state_t st_next;
	logic [W-1:0]    last_count;

	// Ratio zero behaves as one rather than stalling
	assign last_count = (ratio_in == '0) ? '0 : ratio_in - W'(1);

	always_comb
	begin
		st_next      = st_reg;
		st_next.tick = 1'b0;
		if (tick_in)
		begin
			// Wrap also covers a ratio lowered below the running count
			if (st_reg.count >= last_count)
			begin
				st_next.count = '0;
				st_next.tick  = 1'b1;
			end
			else
			begin
				st_next.count = st_reg.count + W'(1);
			end
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tick_out = st_reg.tick;

endmodule // ustc_clk_div

`default_nettype wire

//--- logic/ustc_clock_ctrl.sv
// Oscillator tuning register and USB / core clock derivation with APB access
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module ustc_clock_ctrl
	import ustc_pkg::*;
(
	input  wire logic                        core_clk_in,
	input  wire logic                        rst_n_in,
	// APB slave
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [ustc_pkg::ADDR_W-1:0] paddr_in,
	input  wire logic [ustc_pkg::DATA_W-1:0] pwdata_in,
	output logic [ustc_pkg::DATA_W-1:0]      prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	// Configuration and clock source ticks
	input  wire logic                        config_multiplier_enable_in,
	input  wire logic                        sys_clk_is_48_in,
	input  wire logic                        fast_internal_osc_tick_in,
	input  wire logic                        slow_internal_rc_tick_in,
	input  wire logic                        primary_osc_tick_in,
	input  wire logic                        pll_48_tick_in,
	input  wire logic                        sys_clk_tick_in,
	// Derived outputs
	output logic                             freq_multiplier_on_out,
	output logic                             low_freq_tick_out,
	output logic                             cpu_clk_tick_out,
	output logic                             usb_clk_tick_out,
	output logic [ustc_pkg::TRIM_W-1:0]      trim_code_out,
	output logic                             usb_cfg_ok_out
);

	// ----------------------------------------------------------------
	// Register layout
	// ----------------------------------------------------------------
	// Registers are one byte; the rest of the bus word reads zero
	localparam int               REG_W    = 8;
	localparam int               PAD_W    = DATA_W - REG_W;
	localparam logic [PAD_W-1:0] PAD_ZERO = '0;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [REG_W-1:0]  osc_tuning;
		logic [REG_W-1:0]  div_ctrl;
		logic [DATA_W-1:0] rdata;
		logic              slverr;
		logic              pll_on;
		logic              lf_tick;
		logic              usb_tick;
		logic              cfg_ok;
	} ustc_ctrl_state_t;

	ustc_ctrl_state_t st_reg;
	ustc_ctrl_state_t st_next;

	// ----------------------------------------------------------------
	// Decoded fields
	// ----------------------------------------------------------------
	logic              low_freq_source_select;
	logic              freq_multiplier_enable;
	logic [TRIM_W-1:0] trim_field;
	logic [1:0]        cpu_clock_divider;
	logic              low_speed_prescale_select;
	logic              ls_src_pll;
	logic              full_speed_sel;

	assign low_freq_source_select    = st_reg.osc_tuning[LF_SRC_BIT];
	assign freq_multiplier_enable    = st_reg.osc_tuning[PLL_EN_BIT];
	assign trim_field                = st_reg.osc_tuning[TRIM_MSB:TRIM_LSB];
	assign cpu_clock_divider         = st_reg.div_ctrl[CPU_DIV_MSB:CPU_DIV_LSB];
	assign low_speed_prescale_select = st_reg.div_ctrl[LS_PRESCALE_BIT];
	assign ls_src_pll                = st_reg.div_ctrl[LS_SRC_PLL_BIT];
	assign full_speed_sel            = st_reg.div_ctrl[FULL_SPEED_BIT];

	// ----------------------------------------------------------------
	// Divider ratio selection
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] cpu_ratio;
	logic [DIV_W-1:0] usb_ratio;
	logic             pll_tick_gated;
	logic             ls_src_tick;
	logic             lf_div_tick;
	logic             cpu_div_tick;
	logic             ls_div_tick;
	logic             trim_centre;

	always_comb
	begin
		unique case (cpu_clock_divider)
			CPU_CODE_DIV1: cpu_ratio = CPU_RATIO_1;
			CPU_CODE_DIV2: cpu_ratio = CPU_RATIO_2;
			CPU_CODE_DIV3: cpu_ratio = CPU_RATIO_3;
			CPU_CODE_DIV6: cpu_ratio = CPU_RATIO_6;
		endcase
	end

	// Ratio follows the prescale bit; a mismatch with the system clock only flags status
	always_comb
	begin
		if (low_speed_prescale_select)
			usb_ratio = USB_RATIO_48;
		else
			usb_ratio = USB_RATIO_24;
	end

	// ----------------------------------------------------------------
	// Low-Speed source
	// ----------------------------------------------------------------
	// A stopped PLL must not feed any USB path
	assign pll_tick_gated = st_reg.pll_on & pll_48_tick_in;
	assign ls_src_tick    = ls_src_pll ? pll_tick_gated : primary_osc_tick_in;

	// ----------------------------------------------------------------
	// Dividers and trim
	// ----------------------------------------------------------------
	// Fixed divide by 256 for the slow device clock
	ustc_clk_div #(
		.W (DIV_W)
	) u_lf_div (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.tick_in     (fast_internal_osc_tick_in),
		.ratio_in    (LF_DIV_RATIO),
		.tick_out    (lf_div_tick)
	);

	// CPU divider is independent of the USB divider
	ustc_clk_div #(
		.W (DIV_W)
	) u_cpu_div (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.tick_in     (sys_clk_tick_in),
		.ratio_in    (cpu_ratio),
		.tick_out    (cpu_div_tick)
	);

	ustc_clk_div #(
		.W (DIV_W)
	) u_usb_ls_div (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.tick_in     (ls_src_tick),
		.ratio_in    (usb_ratio),
		.tick_out    (ls_div_tick)
	);

	ustc_trim_map u_trim (
		.core_clk_in     (core_clk_in),
		.rst_n_in        (rst_n_in),
		.trim_field_in   (trim_field),
		.trim_code_out   (trim_code_out),
		.trim_centre_out (trim_centre)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic              apb_setup;
	logic              apb_access;
	logic              hit_tuning;
	logic              hit_div;
	logic              hit_status;
	logic              addr_mapped;
	logic              wr_tuning;
	logic              wr_div;
	logic [REG_W-1:0]  wdata_byte;

	assign apb_setup   = psel_in & ~penable_in;
	assign apb_access  = psel_in & penable_in;
	assign hit_tuning  = (paddr_in == OSC_TUNING_ADDR);
	assign hit_div     = (paddr_in == DIV_CTRL_ADDR);
	assign hit_status  = (paddr_in == CLK_STATUS_ADDR);
	assign addr_mapped = hit_tuning | hit_div | hit_status;
	// Status is read-only; writes to it are ignored without error
	assign wr_tuning   = apb_access & pwrite_in & hit_tuning;
	assign wr_div      = apb_access & pwrite_in & hit_div;
	assign wdata_byte  = pwdata_in[REG_W-1:0];

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] rdata_sel;

	always_comb
	begin
		status_word                 = RDATA_ZERO;
		status_word[ST_PLL_ON]      = st_reg.pll_on;
		status_word[ST_LF_DIVIDED]  = low_freq_source_select;
		status_word[ST_USB_CFG_OK]  = st_reg.cfg_ok;
		status_word[ST_FULL_SPEED]  = full_speed_sel;
		status_word[ST_TRIM_CENTRE] = trim_centre;
	end

	// Unmapped and misaligned addresses read zero
	always_comb
	begin
		if (hit_tuning)
			rdata_sel = {PAD_ZERO, st_reg.osc_tuning};
		else if (hit_div)
			rdata_sel = {PAD_ZERO, st_reg.div_ctrl};
		else if (hit_status)
			rdata_sel = status_word;
		else
			rdata_sel = RDATA_ZERO;
	end

	// ----------------------------------------------------------------
	// Clock source selection
	// ----------------------------------------------------------------
	logic pll_on_next;
	logic lf_tick_next;
	logic usb_tick_next;
	logic ls_pair_ok;
	logic cfg_ok_next;

	// Configuration enable overrides a cleared register bit
	assign pll_on_next   = freq_multiplier_enable | config_multiplier_enable_in;
	assign lf_tick_next  = low_freq_source_select ? lf_div_tick : slow_internal_rc_tick_in;
	// Full-Speed takes the 48 MHz PLL tick, Low-Speed the divided 6 MHz tick
	assign usb_tick_next = full_speed_sel ? pll_tick_gated : ls_div_tick;
	// A prescale that does not match the system clock only clears the status
	assign ls_pair_ok    = (low_speed_prescale_select == sys_clk_is_48_in);
	// Full-Speed needs a running PLL
	assign cfg_ok_next   = full_speed_sel ? st_reg.pll_on : ls_pair_ok;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;

		// Read data and error are captured in setup so they come from flops
		if (apb_setup)
		begin
			st_next.slverr = ~addr_mapped;
			st_next.rdata  = rdata_sel;
		end

		if (wr_tuning)
			st_next.osc_tuning = wdata_byte;
		if (wr_div)
			st_next.div_ctrl = wdata_byte & DIV_CTRL_MASK;

		// Levels and ticks are registered so outputs come from flops
		st_next.pll_on   = pll_on_next;
		st_next.lf_tick  = lf_tick_next;
		st_next.usb_tick = usb_tick_next;
		st_next.cfg_ok   = cfg_ok_next;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			st_reg            <= '0;
			st_reg.osc_tuning <= OSC_TUNING_RST;
			st_reg.div_ctrl   <= DIV_CTRL_RST;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Bus outputs
	// ----------------------------------------------------------------
	// Zero wait states keep the slave simple; every access ends in one access cycle
	assign pready_out  = 1'b1;
	assign prdata_out  = st_reg.rdata;
	assign pslverr_out = st_reg.slverr & apb_access;

	// ----------------------------------------------------------------
	// Clock outputs
	// ----------------------------------------------------------------
	// Pulses last one core clock
	assign freq_multiplier_on_out = st_reg.pll_on;
	assign low_freq_tick_out      = st_reg.lf_tick;
	assign cpu_clk_tick_out       = cpu_div_tick;
	assign usb_clk_tick_out       = st_reg.usb_tick;
	assign usb_cfg_ok_out         = st_reg.cfg_ok;

endmodule // ustc_clock_ctrl

`default_nettype wire

//--- logic/ustc_pkg.sv
// Shared constants for the oscillator tuning and USB clock control block
package ustc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 32;
	localparam int          IDX_W           = 12;
	localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;
	localparam logic [1:0]  WORD_ALIGN      = 2'h0;

	// ----------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] OSC_TUNING_IDX = 12'hf9b;
	localparam logic [IDX_W-1:0] DIV_CTRL_IDX   = 12'hf9c;
	localparam logic [IDX_W-1:0] CLK_STATUS_IDX = 12'hf9d;

	localparam logic [ADDR_W-1:0] OSC_TUNING_ADDR = {2'h0, OSC_TUNING_IDX, WORD_ALIGN};
	localparam logic [ADDR_W-1:0] DIV_CTRL_ADDR   = {2'h0, DIV_CTRL_IDX, WORD_ALIGN};
	localparam logic [ADDR_W-1:0] CLK_STATUS_ADDR = {2'h0, CLK_STATUS_IDX, WORD_ALIGN};

	// ----------------------------------------------------------------
	// osc_tuning fields
	// ----------------------------------------------------------------
	localparam int         LF_SRC_BIT      = 7;
	localparam int         PLL_EN_BIT      = 6;
	localparam int         TRIM_MSB        = 5;
	localparam int         TRIM_LSB        = 0;
	localparam int         TRIM_W          = 6;
	localparam logic [7:0] OSC_TUNING_RST  = 8'h00;
	localparam logic [5:0] TRIM_SIGN_FLIP  = 6'h20;

	// ----------------------------------------------------------------
	// div_ctrl fields
	// ----------------------------------------------------------------
	localparam int         CPU_DIV_LSB     = 0;
	localparam int         CPU_DIV_MSB     = 1;
	localparam int         LS_PRESCALE_BIT = 2;
	localparam int         LS_SRC_PLL_BIT  = 3;
	localparam int         FULL_SPEED_BIT  = 4;
	localparam logic [7:0] DIV_CTRL_MASK   = 8'h1f;
	localparam logic [7:0] DIV_CTRL_RST    = 8'h07;

	// ----------------------------------------------------------------
	// clk_status fields
	// ----------------------------------------------------------------
	localparam int ST_PLL_ON       = 0;
	localparam int ST_LF_DIVIDED   = 1;
	localparam int ST_USB_CFG_OK   = 2;
	localparam int ST_FULL_SPEED   = 3;
	localparam int ST_TRIM_CENTRE  = 4;

	// ----------------------------------------------------------------
	// Divide ratios
	// ----------------------------------------------------------------
	localparam int         DIV_W          = 9;
	localparam logic [8:0] LF_DIV_RATIO   = 9'h100;
	localparam logic [8:0] CPU_RATIO_1    = 9'h001;
	localparam logic [8:0] CPU_RATIO_2    = 9'h002;
	localparam logic [8:0] CPU_RATIO_3    = 9'h003;
	localparam logic [8:0] CPU_RATIO_6    = 9'h006;
	localparam logic [8:0] USB_RATIO_48   = 9'h008;
	localparam logic [8:0] USB_RATIO_24   = 9'h004;

	localparam logic [1:0] CPU_CODE_DIV1  = 2'h3;
	localparam logic [1:0] CPU_CODE_DIV2  = 2'h2;
	localparam logic [1:0] CPU_CODE_DIV3  = 2'h1;
	localparam logic [1:0] CPU_CODE_DIV6  = 2'h0;

endpackage

//--- logic/ustc_trim_map.sv
// Signed trim field to monotonic offset-binary oscillator code
`timescale 1ns/1ps
`default_nettype none

module ustc_trim_map
	import ustc_pkg::*;
(
	input  wire logic                       core_clk_in,
	input  wire logic                       rst_n_in,
	input  wire logic [ustc_pkg::TRIM_W-1:0] trim_field_in,
	output logic [ustc_pkg::TRIM_W-1:0]      trim_code_out,
	output logic                            trim_centre_out
);

	typedef struct packed {
		logic [TRIM_W-1:0] code;
		logic              centre;
	} ustc_trim_state_t;

	ustc_trim_state_t st_reg;
	ustc_trim_state_t st_next;

	always_comb
	begin
		st_next        = st_reg;
		// Sign flip: 100000 -> lowest code, 000000 -> mid, 011111 -> highest
		st_next.code   = trim_field_in ^ TRIM_SIGN_FLIP;
		st_next.centre = (trim_field_in == '0);
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			st_reg <= '{code: TRIM_SIGN_FLIP, centre: 1'b1};
		else
			st_reg <= st_next;
	end

	assign trim_code_out   = st_reg.code;
	assign trim_centre_out = st_reg.centre;

endmodule // ustc_trim_map

`default_nettype wire

//--- test/ustc_clock_ctrl_asserts.sv
// Port checker for the clock control block
`timescale 1ns/1ps
`default_nettype none

module ustc_clock_ctrl_asserts
	import ustc_pkg::*;
(
	input wire logic                        core_clk_in,
	input wire logic                        rst_n_in,
	input wire logic                        psel_in,
	input wire logic                        penable_in,
	input wire logic                        pwrite_in,
	input wire logic [ustc_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [ustc_pkg::DATA_W-1:0] pwdata_in,
	input wire logic [ustc_pkg::DATA_W-1:0] prdata_out,
	input wire logic                        pready_out,
	input wire logic                        pslverr_out,
	input wire logic                        config_multiplier_enable_in,
	input wire logic                        fast_internal_osc_tick_in,
	input wire logic                        slow_internal_rc_tick_in,
	input wire logic                        primary_osc_tick_in,
	input wire logic                        pll_48_tick_in,
	input wire logic                        sys_clk_tick_in,
	input wire logic                        freq_multiplier_on_out,
	input wire logic                        low_freq_tick_out,
	input wire logic                        cpu_clk_tick_out,
	input wire logic                        usb_clk_tick_out,
	input wire logic [ustc_pkg::TRIM_W-1:0] trim_code_out
);
	logic acc;
	logic mapped;
	assign acc = psel_in && penable_in;
	assign mapped = paddr_in inside {OSC_TUNING_ADDR, DIV_CTRL_ADDR, CLK_STATUS_ADDR};

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// ----
	// Bus
	// ----
	a_pready_on: assert property (acc |-> pready_out) else $error("pready low in access");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr_out) else $error("no error on unmapped");
	a_err_mapped: assert property (acc && mapped |-> !pslverr_out) else $error("error on mapped");
	a_read_upper: assert property (acc && !pwrite_in |-> prdata_out[31:8] == '0) else $error("upper read bits");

	// ----
	// Clocks
	// ----
	a_trim_offset: assert property (
		acc && pwrite_in && paddr_in == OSC_TUNING_ADDR |-> ##2 trim_code_out == ($past(pwdata_in[5:0], 2) ^ TRIM_SIGN_FLIP))
		else $error("trim code wrong");
	a_pll_cfg: assert property (
		$past(config_multiplier_enable_in) && $past(rst_n_in) && $past(rst_n_in, 2) |-> freq_multiplier_on_out)
		else $error("pll off under config");
	a_pll_drop: assert property ($fell(freq_multiplier_on_out) |-> !$past(config_multiplier_enable_in))
		else $error("pll dropped under config");
	a_cpu_cause: assert property (cpu_clk_tick_out |-> $past(sys_clk_tick_in))
		else $error("cpu tick without source");
	a_usb_cause: assert property (
		usb_clk_tick_out |-> $past(pll_48_tick_in) || $past(primary_osc_tick_in, 2) || $past(pll_48_tick_in, 2))
		else $error("usb tick without source");
	a_lf_cause: assert property (
		low_freq_tick_out |-> $past(slow_internal_rc_tick_in) || $past(fast_internal_osc_tick_in, 2))
		else $error("low freq tick without source");
endmodule // ustc_clock_ctrl_asserts

bind ustc_clock_ctrl ustc_clock_ctrl_asserts chk_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.config_multiplier_enable_in(config_multiplier_enable_in),
	.fast_internal_osc_tick_in(fast_internal_osc_tick_in), .slow_internal_rc_tick_in(slow_internal_rc_tick_in),
	.primary_osc_tick_in(primary_osc_tick_in), .pll_48_tick_in(pll_48_tick_in),
	.sys_clk_tick_in(sys_clk_tick_in), .freq_multiplier_on_out(freq_multiplier_on_out),
	.low_freq_tick_out(low_freq_tick_out), .cpu_clk_tick_out(cpu_clk_tick_out),
	.usb_clk_tick_out(usb_clk_tick_out), .trim_code_out(trim_code_out));

`default_nettype wire

//--- test/ustc_clock_ctrl_bench.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none

module ustc_clock_ctrl_bench;
	import ustc_pkg::*;
	logic              core_clk_in = 1'b0;
	logic              rst_n_in = 1'b0;
	logic              psel_in = 1'b0;
	logic              penable_in = 1'b0;
	logic              pwrite_in = 1'b0;
	logic [ADDR_W-1:0] paddr_in = '0;
	logic [DATA_W-1:0] pwdata_in = '0;
	logic              config_multiplier_enable_in = 1'b0;
	logic              sys_clk_is_48_in = 1'b1;
	logic [4:0]        src = '0;
	logic [DATA_W-1:0] prdata_out;
	logic [DATA_W-1:0] rd;
	logic              pready_out;
	logic              pslverr_out;
	logic              freq_multiplier_on_out;
	logic              low_freq_tick_out;
	logic              cpu_clk_tick_out;
	logic              usb_clk_tick_out;
	logic              usb_cfg_ok_out;
	logic [5:0]        trim_code_out;
	logic [2:0][15:0]  cnt;
	logic [5:0]        tv [4] = '{6'h1f, 6'h00, 6'h20, 6'h3f};
	int                cpu_n [4] = '{1, 2, 3, 6};
	int                err_total = 0;
	int                checks = 0;

	always #12.5 core_clk_in = ~core_clk_in;

	ustc_clock_ctrl dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.config_multiplier_enable_in(config_multiplier_enable_in), .sys_clk_is_48_in(sys_clk_is_48_in),
		.fast_internal_osc_tick_in(src[0]), .slow_internal_rc_tick_in(src[1]), .primary_osc_tick_in(src[2]),
		.pll_48_tick_in(src[3]), .sys_clk_tick_in(src[4]), .freq_multiplier_on_out(freq_multiplier_on_out),
		.low_freq_tick_out(low_freq_tick_out), .cpu_clk_tick_out(cpu_clk_tick_out),
		.usb_clk_tick_out(usb_clk_tick_out), .trim_code_out(trim_code_out), .usb_cfg_ok_out(usb_cfg_ok_out));

	ustc_tick_sink sink_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.tick_in({usb_clk_tick_out, cpu_clk_tick_out, low_freq_tick_out}), .cnt_out(cnt));

	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Idle edge first, so a request never follows a release in one step
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e);
		int n;
		@(posedge core_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 8);
		if (pready_out !== 1'b1)
		begin
			err_total++;
			print_verdict();
		end
		else
		begin
			rd = prdata_out;
			chk("pslverr", 32'(e), 32'(pslverr_out));
			psel_in <= 1'b0;
			penable_in <= 1'b0;
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask

	task automatic rdc(input logic [15:0] a, input logic [31:0] e, input logic err);
		apb(1'b0, a, 32'h0000_0000, err);
		chk("prdata", e, rd);
	endtask

	task automatic lvl(input string nm, input logic e, input int i);
		repeat (3) @(posedge core_clk_in);
		chk(nm, 32'(e), 32'(i == 0 ? freq_multiplier_on_out : usb_cfg_ok_out));
	endtask

	// Source w gets n ticks; sink k must count e more
	task automatic run(input int w, input int n, input int k, input int e);
		logic [15:0] c0;
		c0 = cnt[k];
		repeat (n)
		begin
			src[w] <= 1'b1;
			@(posedge core_clk_in);
		end
		src[w] <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		chk("tick count", 32'(e), 32'(cnt[k] - c0));
	endtask

	// ----
	// Sequence
	// ----
	initial
	begin
		repeat (10) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		rdc(OSC_TUNING_ADDR, 32'h0000_0000, 1'b0);
		rdc(DIV_CTRL_ADDR, 32'h0000_0007, 1'b0);
		rdc(16'h0100, 32'h0000_0000, 1'b1);
		rdc(OSC_TUNING_ADDR + 16'h0001, 32'h0000_0000, 1'b1);
		foreach (tv[i])
		begin
			wr(OSC_TUNING_ADDR, 32'(tv[i]));
			rdc(OSC_TUNING_ADDR, 32'(tv[i]), 1'b0);
			chk("trim code", 32'(tv[i] ^ TRIM_SIGN_FLIP), 32'(trim_code_out));
		end
		wr(OSC_TUNING_ADDR, 32'h0000_0040);
		lvl("pll on", 1'b1, 0);
		wr(OSC_TUNING_ADDR, 32'h0000_0000);
		lvl("pll off", 1'b0, 0);
		config_multiplier_enable_in <= 1'b1;
		lvl("pll config", 1'b1, 0);
		wr(OSC_TUNING_ADDR, 32'h0000_0040);
		wr(OSC_TUNING_ADDR, 32'h0000_0000);
		lvl("pll held", 1'b1, 0);
		config_multiplier_enable_in <= 1'b0;
		lvl("pll released", 1'b0, 0);
		wr(OSC_TUNING_ADDR, 32'h0000_0080);
		run(0, 512, 0, 2);
		run(1, 5, 0, 0);
		wr(OSC_TUNING_ADDR, 32'h0000_0000);
		run(1, 5, 0, 5);
		foreach (cpu_n[i])
		begin
			wr(DIV_CTRL_ADDR, 32'(7 - i));
			run(4, 12, 1, 12 / cpu_n[i]);
		end
		wr(DIV_CTRL_ADDR, 32'h0000_0007);
		lvl("usb cfg", 1'b1, 1);
		run(2, 16, 2, 2);
		sys_clk_is_48_in <= 1'b0;
		lvl("usb cfg", 1'b0, 1);
		wr(DIV_CTRL_ADDR, 32'h0000_0003);
		lvl("usb cfg", 1'b1, 1);
		run(2, 16, 2, 4);
		wr(OSC_TUNING_ADDR, 32'h0000_0040);
		wr(DIV_CTRL_ADDR, 32'h0000_000b);
		run(3, 16, 2, 4);
		run(2, 16, 2, 0);
		wr(DIV_CTRL_ADDR, 32'h0000_0013);
		lvl("usb cfg", 1'b1, 1);
		run(3, 5, 2, 5);
		wr(CLK_STATUS_ADDR, 32'h0000_0000);
		rdc(CLK_STATUS_ADDR, 32'h0000_001d, 1'b0);
		wr(OSC_TUNING_ADDR, 32'h0000_0000);
		lvl("usb cfg", 1'b0, 1);
		run(3, 5, 2, 0);
		print_verdict();
	end
endmodule // ustc_clock_ctrl_bench

`default_nettype wire

//--- test/ustc_tick_sink.sv
// Consumer model: counts the clock ticks taken by the USB module, the CPU core and the low-frequency logic
`timescale 1ns/1ps
`default_nettype none

module ustc_tick_sink (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [2:0]  tick_in,
	output logic [2:0][15:0] cnt_out
);
	// ----
	// Tick counters
	// ----
	// Counters wrap silently; runs stay far below 16 bits
	always_ff @(posedge core_clk_in)
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (!rst_n_in)
				cnt_out[i] <= '0;
			else
				cnt_out[i] <= cnt_out[i] + 16'(tick_in[i]);
		end
	end
endmodule // ustc_tick_sink

`default_nettype wire
